// [core/smwfc_static_mem_ctrl.sv]
// Access sequencer with float waits, external wait and slow clock mode
`timescale 1ns/100ps
`include "smwfc_consts.svh"
module smwfc_static_mem_ctrl
  import smwfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [2:0] req_cs_in,
  input wire logic [7:0] rd_setup_in,
  input wire logic [7:0] rd_pulse_in,
  input wire logic [7:0] csrd_setup_in,
  input wire logic [7:0] csrd_pulse_in,
  input wire logic [8:0] rd_cycle_in,
  input wire logic [7:0] wr_setup_in,
  input wire logic [7:0] wr_pulse_in,
  input wire logic [7:0] cswr_setup_in,
  input wire logic [7:0] cswr_pulse_in,
  input wire logic [8:0] wr_cycle_in,
  input wire logic read_mode_in,
  input wire logic write_mode_in,
  input wire logic float_opt_in,
  input wire logic [3:0] float_cycles_in,
  input wire logic [1:0] ext_wait_mode_in,
  input wire logic slow_clock_in,
  input wire logic ext_wait_n_in,
  output logic req_ready_out,
  output logic done_out,
  output logic chip_select_n_out,
  output logic [2:0] cs_index_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic [2:0] state_out
);
  // =====================================================================
  // Reset release
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_b = rst_s2_reg;

  // =====================================================================
  // Wait synchroniser
  smwfc_wait_if wif ();
  smwfc_wait_sync u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .ce_in(ce_in),
    .ext_wait_n_in(ext_wait_n_in),
    .wif(wif)
  );

  // =====================================================================
  // Timing selection
  function automatic logic [7:0] sat_dec(input logic [7:0] v);
    sat_dec = (v == 8'h00) ? 8'h00 : v - 8'h01;
  endfunction

  smwfc_state_type state_reg, state_next;
  logic [8:0] cnt_reg, cnt_next;
  logic write_reg, write_next;
  logic slow_reg, slow_next;
  logic [2:0] cs_reg, cs_next;
  logic last_rd_reg, last_rd_next;
  logic [3:0] float_reg, float_next;
  logic [1:0] wmode_reg, wmode_next;
  logic ctl_mode_reg, ctl_mode_next;
  logic slow_seen_reg, slow_seen_next;
  smwfc_timing_type tim_reg, tim_next;
  logic cs_n_reg, cs_n_next;
  logic rd_n_reg, rd_n_next;
  logic wr_n_reg, wr_n_next;
  logic done_reg, done_next;

  smwfc_timing_type slow_rd_t;
  smwfc_timing_type slow_wr_t;
  smwfc_timing_type user_t;
  wire use_slow = slow_clock_in; // RL13
  assign slow_rd_t = '{`SMWFC_SLOW_RD_SETUP, `SMWFC_SLOW_RD_PULSE,
                       `SMWFC_SLOW_CSRD_SETUP, `SMWFC_SLOW_CSRD_PULSE,
                       {1'b0, `SMWFC_SLOW_RD_CYCLE}}; // RL14
  assign slow_wr_t = '{`SMWFC_SLOW_WR_SETUP, `SMWFC_SLOW_WR_PULSE,
                       `SMWFC_SLOW_CSWR_SETUP, `SMWFC_SLOW_CSWR_PULSE,
                       {1'b0, `SMWFC_SLOW_WR_CYCLE}}; // RL15
  assign user_t = req_write_in ?
    {wr_setup_in, wr_pulse_in, cswr_setup_in, cswr_pulse_in, wr_cycle_in} :
    {rd_setup_in, rd_pulse_in, csrd_setup_in, csrd_pulse_in, rd_cycle_in};
  wire smwfc_timing_type sel_t = use_slow ?
    (req_write_in ? slow_wr_t : slow_rd_t) : user_t;

  // =====================================================================
  // Phase decode inside access
  wire [8:0] ctl_setup = ctl_mode_reg ? {1'b0, tim_reg.setup} :
                                        {1'b0, tim_reg.cs_setup};
  wire [8:0] ctl_pulse = ctl_mode_reg ? {1'b0, tim_reg.pulse} :
                                        {1'b0, tim_reg.cs_pulse};
  wire [8:0] ctl_end = ctl_setup + ctl_pulse;
  wire in_pulse = (cnt_reg >= ctl_setup) && (cnt_reg < ctl_end); // RL7
  wire last_pulse = (cnt_reg == ctl_end - 9'h001);
  wire frozen = (wmode_reg == `SMWFC_WAIT_FROZEN) && in_pulse &&
                wif.wait_sync; // RL6 RL9
  wire ready_hold = (wmode_reg == `SMWFC_WAIT_READY) && last_pulse &&
                    wif.wait_sync; // RL6 RL10 RL11
  wire cyc_last = (cnt_reg + 9'h001 >= tim_reg.cycle);
  wire [7:0] float_dec = sat_dec({4'h0, float_reg});
  // Hold cycles after the controlling strobe rise already count as float
  wire [8:0] ctl_hold = (tim_reg.cycle > ctl_end) ?
                        tim_reg.cycle - ctl_end : 9'h000;
  wire [8:0] float_left9 = ({5'h00, float_reg} > ctl_hold) ?
                           {5'h00, float_reg} - ctl_hold : 9'h000; // RL5
  // Float only matters for reads before another device or any write
  wire float_needed = last_rd_reg &&
                      (req_write_in || (req_cs_in != cs_reg)); // RL19
  wire [7:0] next_setup = sel_t.setup < sel_t.cs_setup ?
                          sel_t.setup : sel_t.cs_setup;
  // With optimisation the next access setup absorbs remaining float
  wire float_block = float_needed && (float_reg != 4'h0) &&
    (!float_opt_in || ({4'h0, float_reg} > next_setup)); // RL3 RL4
  wire slow_change = slow_clock_in != slow_seen_reg;

  // =====================================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    write_next = write_reg;
    slow_next = slow_reg;
    cs_next = cs_reg;
    last_rd_next = last_rd_reg;
    float_next = float_reg;
    wmode_next = wmode_reg;
    ctl_mode_next = ctl_mode_reg;
    slow_seen_next = slow_seen_reg;
    tim_next = tim_reg;
    done_next = 1'b0;
    case (state_reg)
      SMWFC_IDLE: begin
        if (slow_change) begin
          state_next = SMWFC_RELOAD; // RL17
        end else if (req_valid_in && float_block) begin
          // Held off: the float period keeps running down meanwhile
          float_next = float_dec[3:0]; // RL3
          if (!float_opt_in && float_reg > 4'h1) begin
            state_next = SMWFC_FLOAT; // RL4
          end
        end else if (req_valid_in) begin
          state_next = SMWFC_ACCESS;
          cnt_next = 9'h000;
          write_next = req_write_in;
          cs_next = req_cs_in;
          slow_next = use_slow;
          tim_next = sel_t;
          ctl_mode_next = req_write_in ? write_mode_in : read_mode_in;
          // Wait unsupported in slow mode, forced off there
          wmode_next = use_slow ? `SMWFC_WAIT_OFF : ext_wait_mode_in;
          float_next = float_cycles_in; // RL18
          last_rd_next = 1'b0;
        end else if (float_reg != 4'h0) begin
          float_next = float_dec[3:0];
        end
      end
      SMWFC_ACCESS: begin
        if (ready_hold) begin
          state_next = SMWFC_READY_WAIT; // RL10
        end else if (!frozen) begin
          cnt_next = cnt_reg + 9'h001;
          if (cyc_last) begin
            done_next = 1'b1;
            last_rd_next = !write_reg;
            float_next = write_reg ? 4'h0 : float_left9[3:0]; // RL1 RL2 RL18
            // Float waits wait for the next request, it decides if needed
            state_next = slow_change ? SMWFC_RELOAD : SMWFC_IDLE;
          end
        end
      end
      SMWFC_READY_WAIT: begin
        if (!wif.wait_sync) begin
          state_next = SMWFC_ACCESS;
          cnt_next = cnt_reg + 9'h001;
        end
      end
      SMWFC_FLOAT: begin
        float_next = float_dec[3:0]; // RL4
        if (float_reg <= 4'h1) begin
          last_rd_next = 1'b0;
          state_next = slow_change ? SMWFC_RELOAD : SMWFC_IDLE;
        end
      end
      SMWFC_RELOAD: begin
        slow_seen_next = slow_clock_in; // RL17
        state_next = SMWFC_IDLE;
      end
      default: state_next = SMWFC_IDLE;
    endcase
  end

  // =====================================================================
  // Strobe outputs
  wire accessing = (state_next == SMWFC_ACCESS) ||
                   (state_next == SMWFC_READY_WAIT);
  // Slow set persists to transfer end even if slow clock drops
  wire smwfc_timing_type t_n = tim_next; // RL16
  wire [8:0] c_n = cnt_next;
  wire [8:0] st_end_n = {1'b0, t_n.setup} + {1'b0, t_n.pulse};
  wire [8:0] cs_end_n = {1'b0, t_n.cs_setup} + {1'b0, t_n.cs_pulse};
  wire strobe_on = accessing && (c_n >= {1'b0, t_n.setup}) &&
                   (c_n < st_end_n);
  wire cs_on = accessing && (c_n >= {1'b0, t_n.cs_setup}) &&
               (c_n < cs_end_n);
  always_comb begin
    cs_n_next = ~cs_on;
    rd_n_next = ~(strobe_on && !write_next);
    wr_n_next = ~(strobe_on && write_next);
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= SMWFC_IDLE;
      cnt_reg <= 9'h000;
      write_reg <= 1'b0;
      slow_reg <= 1'b0;
      cs_reg <= 3'h0;
      last_rd_reg <= 1'b0;
      float_reg <= 4'h0;
      wmode_reg <= `SMWFC_WAIT_OFF;
      ctl_mode_reg <= 1'b0;
      slow_seen_reg <= 1'b0;
      tim_reg <= '0;
      cs_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      done_reg <= 1'b0;
    end else if (ce_in) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      write_reg <= write_next;
      slow_reg <= slow_next;
      cs_reg <= cs_next;
      last_rd_reg <= last_rd_next;
      float_reg <= float_next;
      wmode_reg <= wmode_next;
      ctl_mode_reg <= ctl_mode_next;
      slow_seen_reg <= slow_seen_next;
      tim_reg <= tim_next;
      cs_n_reg <= cs_n_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      done_reg <= done_next;
    end
  end

  // =====================================================================
  // Outputs
  assign req_ready_out = (state_reg == SMWFC_IDLE) && !slow_change &&
                         !float_block && rst_b;
  assign done_out = done_reg;
  assign chip_select_n_out = cs_n_reg;
  assign cs_index_out = cs_reg;
  assign read_strobe_n_out = rd_n_reg;
  assign write_strobe_n_out = wr_n_reg;
  assign state_out = state_reg;
endmodule

// [core/smwfc_wait_sync.sv]
// Two-stage resynchroniser for the external wait input
`timescale 1ns/100ps
module smwfc_wait_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic ext_wait_n_in,
  smwfc_wait_if.sync wif
);
  logic meta_reg;
  logic sync_reg;
  // =====================================================================
  // Resync
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else if (ce_in) begin
      meta_reg <= ext_wait_n_in; // RL12
      sync_reg <= meta_reg;
    end
  end
  assign wif.wait_sync = ~sync_reg;
endmodule

// [inc/smwfc_consts.svh]
// Constants of the static memory wait and float sequencer
// =====================================================================
// Function
// RL1 - Read strobe controlled: float period starts at strobe rise, lasts float count
// RL2 - Chip select controlled: bus busy for float count after select rises
// RL3 - Optimisation on: next access setup counts toward float period
// RL4 - Optimisation off: float waits at read end before next access
// RL5 - Read hold overlapping float period adds no extra waits
// RL6 - Wait mode 00 ignores wait, 10 frozen, 11 ready
// RL7 - Wait input sampled only in pulse phase of controlling strobe
// RL8 - Software programs a hold cycle; no wait with page or slow mode
// RL9 - Frozen: wait asserted halts counters and holds all outputs
// RL10 - Ready: wait tested in last pulse cycle, suspend then hold
// RL11 - Ready: early deassertion or late assertion leaves length unchanged
// RL12 - Wait resynchronised over two cycles; pulse must cover latency plus 3
// RL13 - Slow clock indication selects fixed waveforms on every chip select
// RL14 - Slow read: strobe setup 1 pulse 1, select setup 0 pulse 2, cycle 2
// RL15 - Slow write: strobe setup 1 pulse 1, select setup 0 pulse 3, cycle 3
// RL16 - Leaving slow mode finishes current transfer with slow parameters
// RL17 - Slow mode entry or exit inserts a reload wait after transfer
// RL18 - Float count per chip select ranges 0 to 15 cycles
// RL19 - Float waits only before read to other device or any write
// RL20 - Controller idles memory before switching slow mode
`ifndef SMWFC_CONSTS_SVH
`define SMWFC_CONSTS_SVH
`define SMWFC_WAIT_OFF 2'h0
`define SMWFC_WAIT_FROZEN 2'h2
`define SMWFC_WAIT_READY 2'h3
`define SMWFC_SLOW_RD_SETUP 8'h01
`define SMWFC_SLOW_RD_PULSE 8'h01
`define SMWFC_SLOW_CSRD_SETUP 8'h00
`define SMWFC_SLOW_CSRD_PULSE 8'h02
`define SMWFC_SLOW_RD_CYCLE 8'h02
`define SMWFC_SLOW_WR_SETUP 8'h01
`define SMWFC_SLOW_WR_PULSE 8'h01
`define SMWFC_SLOW_CSWR_SETUP 8'h00
`define SMWFC_SLOW_CSWR_PULSE 8'h03
`define SMWFC_SLOW_WR_CYCLE 8'h03
`define SMWFC_FLOAT_MAX 4'hf
`endif

// [inc/smwfc_pkg.sv]
// Types of the static memory wait and float sequencer
package smwfc_pkg;
  typedef enum logic [2:0] {
    SMWFC_IDLE = 3'h0,
    SMWFC_ACCESS = 3'h1,
    SMWFC_READY_WAIT = 3'h3,
    SMWFC_FLOAT = 3'h2,
    SMWFC_RELOAD = 3'h6
  } smwfc_state_type;
  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] pulse;
    logic [7:0] cs_setup;
    logic [7:0] cs_pulse;
    logic [8:0] cycle;
  } smwfc_timing_type;
endpackage

// [inc/smwfc_wait_if.sv]
// Wait synchroniser link between sequencer and wait synchroniser
`timescale 1ns/100ps
interface smwfc_wait_if;
  logic wait_sync;
  modport sync (output wait_sync);
  modport seq (input wait_sync);
endinterface

// [tb/smwfc_mem_model.sv]
// External memory model that stretches accesses with its wait line
`timescale 1ns/100ps
module smwfc_mem_model (
  input wire logic clk_in,
  input wire logic chip_select_n_in,
  input wire logic [3:0] wait_delay_in,
  input wire logic [3:0] wait_len_in,
  output logic ext_wait_n_out
);
  // ==========================================================
  // Wait window counted from select fall
  logic [4:0] cnt_reg;
  logic in_window;
  always_ff @(posedge clk_in) begin
    if (chip_select_n_in) cnt_reg <= 5'h00;
    else if (cnt_reg != 5'h1f) cnt_reg <= cnt_reg + 5'h01;
  end
  assign in_window = cnt_reg >= {1'b0, wait_delay_in} &&
    cnt_reg < {1'b0, wait_delay_in} + {1'b0, wait_len_in};
  // Pulled up whenever the device is not selected
  assign ext_wait_n_out = !(!chip_select_n_in && in_window);
endmodule

// [tb/smwfc_static_mem_ctrl_assertions.sv]
// Port checker for the static memory wait and float sequencer
`timescale 1ns/100ps
`include "smwfc_consts.svh"
module smwfc_ctrl_assertions
  import smwfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic slow_clock_in,
  input wire logic [1:0] ext_wait_mode_in,
  input wire logic req_ready_out,
  input wire logic done_out,
  input wire logic chip_select_n_out,
  input wire logic read_strobe_n_out,
  input wire logic write_strobe_n_out,
  input wire logic [2:0] state_out
);
  // ==========================================================
  // Properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_done_single: assert property (done_out |=> !done_out)
    else $error("done held longer than one cycle");
  a_float_refuse: assert property (
    state_out == SMWFC_FLOAT |-> !req_ready_out)
    else $error("request accepted during float wait");
  a_access_refuse: assert property (
    state_out == SMWFC_ACCESS |-> !req_ready_out)
    else $error("request accepted during access");
  a_wait_off_mode: assert property (
    ext_wait_mode_in == `SMWFC_WAIT_OFF |-> state_out != SMWFC_READY_WAIT)
    else $error("wait state entered with wait ignored");
  a_ready_suspend: assert property (
    (state_out == SMWFC_READY_WAIT) [*2] |->
    $stable(read_strobe_n_out) && $stable(chip_select_n_out))
    else $error("outputs moved while suspended");
  a_slow_rd_pulse: assert property (
    slow_clock_in && $fell(read_strobe_n_out) |=> $rose(read_strobe_n_out))
    else $error("slow read strobe not one cycle");
  a_slow_wr_pulse: assert property (
    slow_clock_in && $fell(write_strobe_n_out) |-> !chip_select_n_out
    ##1 ($rose(write_strobe_n_out) && !chip_select_n_out))
    else $error("slow write waveform wrong");
  a_reload_slow: assert property (
    state_out == SMWFC_IDLE && $changed(slow_clock_in) |->
    ##[0:3] state_out == SMWFC_RELOAD)
    else $error("no reload wait after slow change");
  c_float: cover property (state_out == SMWFC_FLOAT);
  c_ready_wait: cover property (state_out == SMWFC_READY_WAIT);
  c_reload: cover property (state_out == SMWFC_RELOAD);
endmodule
bind smwfc_static_mem_ctrl smwfc_ctrl_assertions smwfc_ctrl_assertions_inst (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .slow_clock_in(slow_clock_in),
  .ext_wait_mode_in(ext_wait_mode_in), .req_ready_out(req_ready_out),
  .done_out(done_out), .chip_select_n_out(chip_select_n_out),
  .read_strobe_n_out(read_strobe_n_out),
  .write_strobe_n_out(write_strobe_n_out), .state_out(state_out));

// [tb/test_smwfc_static_mem_ctrl.sv]
// Self-checking bench of the static memory wait and float sequencer
`timescale 1ns/100ps
module test_smwfc_static_mem_ctrl;
  logic clk_in = 0, rst_b_in = 0, rv = 0, rw = 0, slow = 0, fopt = 0;
  logic [2:0] rcs = 3'h0;
  logic [1:0] wmode = 2'h0;
  logic [3:0] fcyc = 4'h5, wdel = 4'h0, wlen = 4'h0;
  logic ce = 1'b1, rmode = 1'b1, wrmode = 1'b1;
  // Setup 1, pulse 4, cycle 7: hold 2 and pulse covers sync latency
  logic [7:0] rds = 8'h01, rdp = 8'h04, crs = 8'h00, crp = 8'h07;
  logic [7:0] wrs = 8'h01, wrp = 8'h04, cws = 8'h00, cwp = 8'h07;
  logic [8:0] rdc = 9'h007, wrc = 9'h007;
  logic rdy, done, csn, rdn, wrn, waitn;
  logic [2:0] st;
  int err_total = 0, samples_checked = 0, cycles = 0;
  int len, gap, chip_select_n, nstb, i;
  logic [1:0] wm_t[5] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h3};
  logic [3:0] dl_t[5] = '{4'h1, 4'h1, 4'h1, 4'h5, 4'h0};
  logic [3:0] ln_t[5] = '{4'h4, 4'h4, 4'h4, 4'h2, 4'h1};
  bit ext_t[5] = '{0, 1, 1, 0, 0};
  always #20 clk_in = ~clk_in;
  // ==========================================================
  // Design and far side
  smwfc_static_mem_ctrl smwfc_static_mem_ctrl_inst (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .ce_in(ce), .req_valid_in(rv),
    .req_write_in(rw), .req_cs_in(rcs), .rd_setup_in(rds),
    .rd_pulse_in(rdp), .csrd_setup_in(crs), .csrd_pulse_in(crp),
    .rd_cycle_in(rdc), .wr_setup_in(wrs), .wr_pulse_in(wrp),
    .cswr_setup_in(cws), .cswr_pulse_in(cwp), .wr_cycle_in(wrc),
    .read_mode_in(rmode), .write_mode_in(wrmode), .float_opt_in(fopt),
    .float_cycles_in(fcyc), .ext_wait_mode_in(wmode),
    .slow_clock_in(slow), .ext_wait_n_in(waitn), .req_ready_out(rdy),
    .done_out(done), .chip_select_n_out(csn), .cs_index_out(),
    .read_strobe_n_out(rdn), .write_strobe_n_out(wrn), .state_out(st));
  smwfc_mem_model smwfc_mem_model_inst (.clk_in(clk_in),
    .chip_select_n_in(csn), .wait_delay_in(wdel), .wait_len_in(wlen),
    .ext_wait_n_out(waitn));
  // ==========================================================
  // Tasks
  task automatic end_of_test();
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check_val(input int got, input int exp, input string m);
    samples_checked++;
    if (got != exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, m, got,
        exp);
    end
  endtask
  task automatic check_true(input logic c, input string m);
    samples_checked++;
    if (c !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // One access; leave_slow drops the slow indication right after taking
  task automatic access(input logic w, input logic [2:0] c,
      input logic leave_slow);
    @(posedge clk_in);
    rv <= 1'b1;
    rw <= w;
    rcs <= c;
    gap = 0;
    len = 0;
    chip_select_n = 0;
    nstb = 0;
    @(negedge clk_in);
    while (rdy !== 1'b1 && gap < 40) begin
      gap++;
      @(negedge clk_in);
    end
    @(posedge clk_in);
    rv <= 1'b0;
    if (leave_slow) slow <= 1'b0;
    // The done pulse follows the last access cycle, so it is not counted
    do begin
      @(negedge clk_in);
      if (done !== 1'b1) len++;
      chip_select_n += (csn === 1'b0);
      nstb += ((w ? wrn : rdn) === 1'b0);
    end while (done !== 1'b1 && len < 60);
  endtask
  // ==========================================================
  // Tests
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    access(1'b0, 3'h0, 1'b0);
    check_val(len, 7, "plain read length");
    // Wait modes and windows, with and without extension
    for (i = 0; i < 5; i++) begin
      wmode <= wm_t[i];
      wdel <= dl_t[i];
      wlen <= ln_t[i];
      access(1'b0, 3'h0, 1'b0);
      if (ext_t[i]) check_true(len > 7, "wait not honoured");
      else check_val(len, 7, "wait changed length");
    end
    wmode <= 2'h0;
    wlen <= 4'h0;
    // Float 5 less hold 2; one float cycle hides in the bench turnaround
    access(1'b1, 3'h0, 1'b0);
    check_val(gap, 2, "float wait read to write");
    // Select controlled read has no hold, so all 5 float cycles remain
    rmode <= 1'b0;
    access(1'b0, 3'h0, 1'b0);
    access(1'b0, 3'h1, 1'b0);
    check_val(gap, 4, "float wait other device");
    rmode <= 1'b1;
    access(1'b0, 3'h1, 1'b0);
    check_val(gap, 0, "float wait same device read");
    // A write setup of 3 absorbs the 3 float cycles left
    fopt <= 1'b1;
    wrs <= 8'h03;
    cws <= 8'h03;
    cwp <= 8'h04;
    access(1'b1, 3'h1, 1'b0);
    check_val(gap, 0, "float with optimisation");
    fopt <= 1'b0;
    fcyc <= 4'h0;
    // Fixed slow waveforms
    slow <= 1'b1;
    access(1'b0, 3'h2, 1'b0);
    check_val(len, 2, "slow read length");
    check_val(chip_select_n, 2, "slow read select");
    check_val(nstb, 1, "slow read strobe");
    access(1'b1, 3'h2, 1'b0);
    check_val(len, 3, "slow write length");
    check_val(chip_select_n, 3, "slow write select");
    check_val(nstb, 1, "slow write strobe");
    access(1'b1, 3'h2, 1'b1);
    check_val(len, 3, "slow length kept on leaving");
    check_val(chip_select_n, 3, "slow select kept on leaving");
    check_val(nstb, 1, "slow strobe kept on leaving");
    access(1'b0, 3'h2, 1'b0);
    check_val(len, 7, "normal timing restored");
    end_of_test();
  end
endmodule
